/* File: design/sysctl_defs.svh */
// Operation
// - bit 15 enables downstream read bursts, resets on
// - bit 14 enables upstream read bursts, resets off
// - bit 13 sets on card access, read clears
// - reserved bit 12 always reads one
// - bit 11 busy until stream and delay end
// - bit 10 flags power-up settling delay
// - bit 9 flags power-down settling delay
// - bit 8 high while card interrogation runs
// - reserved bits 7 and 3 read zero
// - bit 6 low-power mode, resets on
// - bit 5 locks identity registers, resets on
// - bit 4 routes card parity errors to syserr
// - bit 2 shows legacy supply selection
// - bit 1 holds both clocks running
// - bit 0 picks wake or ring output
// - neither selected leaves wake pin floating
// - marked bits cleared by global reset only
// - bits 10..8 survive bus reset if wake enabled
// - register sits at offset 80h, function 0
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

`define SC_OFFSET        8'h80
`define SC_FUNC          3'h0

`define BIT_RSVD_HI_LSB  16
`define BIT_BURST_DN     15
`define BIT_BURST_UP     14
`define BIT_ACCESS_SEEN  13
`define BIT_LOW_POWER    6
`define BIT_ID_LOCK      5
`define BIT_PARITY_SERR  4
`define BIT_HOLD_CLOCKS  1
`define BIT_WAKE_SEL     0

`define RST_RSVD_HI      5'h04
`define RST_BURST_DN     1'b1
`define RST_BURST_UP     1'b0
`define RST_LOW_POWER    1'b1
`define RST_ID_LOCK      1'b1
`define RST_PARITY_SERR  1'b0
`define RST_HOLD_CLOCKS  1'b0
`define RST_WAKE_SEL     1'b0
`define RST_SUPPLY_SEL   1'b0

`define CLK_PERIOD_NS    25
`define RISE_SETTLE_US   300
`define FALL_SETTLE_US   300
`define SW_BIT_NS        400
`define SW_DIV           ((`SW_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_BITS          8

`endif

/* File: design/sysctl_pkg.sv */
package sysctl_pkg;

    // configuration access request from the host side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  func;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // configuration access answer
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } cfg_rsp_t;

    // power switch sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b001,
        SEQ_STREAM = 3'b010,
        SEQ_SETTLE = 3'b100
    } seq_state_t;

endpackage

/* File: design/sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter int unsigned W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pinIn,
    output var  logic [W-1:0] levelOut
);
    // three stages per line; a change counts once stages two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_line
        logic s1_q;
        logic s2_q;
        logic s3_q;
        always_ff @(posedge clk) begin
            if (reset) begin
                s1_q        <= RST_VAL[i];
                s2_q        <= RST_VAL[i];
                s3_q        <= RST_VAL[i];
                levelOut[i] <= RST_VAL[i];
            end else begin
                s1_q <= pinIn[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    levelOut[i] <= s3_q;
                end
            end
        end
    end
endmodule // sync3
`default_nettype wire

/* File: design/power_switch_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"
module power_switch_seq #(
    parameter int unsigned RISE_CYC = 1,
    parameter int unsigned FALL_CYC = 1
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 powerReq,
    input  wire logic                 powerUp,
    input  wire logic [`SW_BITS-1:0]  cmdWord,
    input  wire logic                 ctxClear,
    output var  logic                 streamBusy,
    output var  logic                 riseSettle,
    output var  logic                 fallSettle,
    output var  logic                 switchClk,
    output var  logic                 switchData,
    output var  logic                 switchLatch
);
    sysctl_pkg::seq_state_t state_q;
    logic [7:0]         divCnt_q;
    logic [3:0]         bitCnt_q;
    logic [`SW_BITS-1:0] shift_q;
    logic [23:0]        settleCnt_q;
    logic               up_q;

    wire logic bitTick   = (state_q == sysctl_pkg::SEQ_STREAM) &&
                           (divCnt_q == 8'(`SW_DIV - 1));
    wire logic lastBit   = (bitCnt_q == 4'(`SW_BITS - 1));
    wire logic settleEnd = (state_q == sysctl_pkg::SEQ_SETTLE) && (settleCnt_q == 24'h000000);
    wire logic start     = (state_q == sysctl_pkg::SEQ_IDLE) && powerReq;

    // bit-rate divider, runs only while streaming
    always_ff @(posedge clk) begin
        if (reset || state_q != sysctl_pkg::SEQ_STREAM || bitTick) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    // stream out, then wait the settling delay of the chosen direction
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q     <= sysctl_pkg::SEQ_IDLE;
            bitCnt_q    <= 4'h0;
            shift_q     <= '0;
            settleCnt_q <= 24'h000000;
            up_q        <= 1'b0;
        end else begin
            case (state_q)
                sysctl_pkg::SEQ_IDLE: begin
                    if (powerReq) begin
                        state_q  <= sysctl_pkg::SEQ_STREAM;
                        shift_q  <= cmdWord;
                        bitCnt_q <= 4'h0;
                        up_q     <= powerUp;
                    end
                end
                sysctl_pkg::SEQ_STREAM: begin
                    if (bitTick) begin
                        shift_q  <= {shift_q[`SW_BITS-2:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (lastBit) begin
                            state_q     <= sysctl_pkg::SEQ_SETTLE;
                            settleCnt_q <= up_q ? 24'(RISE_CYC - 1) : 24'(FALL_CYC - 1);
                        end
                    end
                end
                sysctl_pkg::SEQ_SETTLE: begin
                    if (settleEnd) begin
                        state_q <= sysctl_pkg::SEQ_IDLE;
                    end else begin
                        settleCnt_q <= settleCnt_q - 24'h000001;
                    end
                end
                default: state_q <= sysctl_pkg::SEQ_IDLE;
            endcase
        end
    end

    // status and pin flops
    always_ff @(posedge clk) begin
        if (reset) begin
            streamBusy  <= 1'b0;
            switchClk   <= 1'b0;
            switchData  <= 1'b0;
            switchLatch <= 1'b0;
        end else begin
            streamBusy  <= (streamBusy || start) && !settleEnd;
            switchClk   <= bitTick;
            switchData  <= (state_q == sysctl_pkg::SEQ_STREAM) ? shift_q[`SW_BITS-1] : 1'b0;
            switchLatch <= bitTick && lastBit;
        end
    end

    // settling flags are wake context: ctxClear drops them, the delay still runs
    always_ff @(posedge clk) begin
        if (reset || ctxClear) begin
            riseSettle <= 1'b0;
            fallSettle <= 1'b0;
        end else begin
            riseSettle <= (riseSettle || (bitTick && lastBit && up_q)) && !settleEnd;
            fallSettle <= (fallSettle || (bitTick && lastBit && !up_q)) && !settleEnd;
        end
    end
endmodule // power_switch_seq
`default_nettype wire

/* File: design/system_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"
module system_control #(
    parameter int unsigned RISE_CYC =
        (`RISE_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned FALL_CYC =
        (`FALL_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 busResetN,
    input  wire sysctl_pkg::cfg_req_t cfgReq,
    output var  sysctl_pkg::cfg_rsp_t cfgRsp,
    input  wire logic                 cardAccess,
    input  wire logic                 powerReq,
    input  wire logic                 powerUp,
    input  wire logic [`SW_BITS-1:0]  powerCmd,
    input  wire logic                 queryStart,
    input  wire logic                 queryDone,
    input  wire logic                 legacySupplyIn,
    input  wire logic                 pmeEnable,
    input  wire logic                 pmeActive,
    input  wire logic                 ringOutEn,
    input  wire logic                 ringIndicateOut,
    input  wire logic                 cardParityErr,
    input  wire logic                 clkrunNIn,
    output var  logic                 clkrunNOut,
    output var  logic                 clkrunNOe,
    output var  logic                 cardClockRunReq,
    output var  logic                 readBurstDownEn,
    output var  logic                 readBurstUpEn,
    output var  logic                 lowPowerEn,
    output var  logic                 idWriteLock,
    output var  logic                 serrReq,
    output var  logic                 wakePinOut,
    output var  logic                 wakePinOe,
    output var  logic                 streamBusy,
    output var  logic                 riseSettle,
    output var  logic                 fallSettle,
    output var  logic                 switchClk,
    output var  logic                 switchData,
    output var  logic                 switchLatch
);
    logic [4:0] rsvdHi_q;
    logic       accessSeen_q;
    logic       queryBusy_q;
    logic       parityToSyserr_q;
    logic       legacySupplySel_q;
    logic       holdClocks_q;
    logic       wakeSel_q;
    logic       busResetNs;
    logic       clkrunNs;

    // bus reset and clock-run pins come from outside this clock domain
    sync3 #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_pin_sync (
        .clk      (clk),
        .reset    (reset),
        .pinIn    ({busResetN, clkrunNIn}),
        .levelOut ({busResetNs, clkrunNs})
    );

    // bus reset clears wake context only while wake events are off
    wire logic ctxClear = !busResetNs && !pmeEnable;

    // decode of the one configuration word, function 0 only
    wire logic hit = (cfgReq.func == `SC_FUNC) &&
                     (cfgReq.addr[7:2] == 6'(`SC_OFFSET >> 2));
    wire logic wrHit = hit && cfgReq.wr;
    wire logic rdHit = hit && cfgReq.rd;
    wire logic wrB0  = wrHit && cfgReq.be[0];
    wire logic wrB1  = wrHit && cfgReq.be[1];
    wire logic wrB2  = wrHit && cfgReq.be[2];
    wire logic rdClr = rdHit && cfgReq.be[1];

    // read image; bits 31..21 are outside this block and read zero
    wire logic [31:0] readWord = {
        11'h000,
        rsvdHi_q,
        readBurstDownEn,
        readBurstUpEn,
        accessSeen_q,
        1'b1,
        streamBusy,
        riseSettle,
        fallSettle,
        queryBusy_q,
        1'b0,
        lowPowerEn,
        idWriteLock,
        parityToSyserr_q,
        1'b0,
        legacySupplySel_q,
        holdClocks_q,
        wakeSel_q
    };

    // power switch stream and settling delay
    power_switch_seq #(
        .RISE_CYC (RISE_CYC),
        .FALL_CYC (FALL_CYC)
    ) u_seq (
        .clk         (clk),
        .reset       (reset),
        .powerReq    (powerReq),
        .powerUp     (powerUp),
        .cmdWord     (powerCmd),
        .ctxClear    (ctxClear),
        .streamBusy  (streamBusy),
        .riseSettle  (riseSettle),
        .fallSettle  (fallSettle),
        .switchClk   (switchClk),
        .switchData  (switchData),
        .switchLatch (switchLatch)
    );

    // writable bits; only the global reset returns them to defaults
    always_ff @(posedge clk) begin
        if (reset) begin
            wakeSel_q        <= `RST_WAKE_SEL;
            holdClocks_q     <= `RST_HOLD_CLOCKS;
            parityToSyserr_q <= `RST_PARITY_SERR;
            idWriteLock      <= `RST_ID_LOCK;
            lowPowerEn       <= `RST_LOW_POWER;
        end else if (wrB0) begin
            wakeSel_q        <= cfgReq.wdata[`BIT_WAKE_SEL];
            holdClocks_q     <= cfgReq.wdata[`BIT_HOLD_CLOCKS];
            parityToSyserr_q <= cfgReq.wdata[`BIT_PARITY_SERR];
            idWriteLock      <= cfgReq.wdata[`BIT_ID_LOCK];
            lowPowerEn       <= cfgReq.wdata[`BIT_LOW_POWER];
        end
    end

    // burst enables and the reserved read/write field
    always_ff @(posedge clk) begin
        if (reset) begin
            readBurstDownEn <= `RST_BURST_DN;
            readBurstUpEn   <= `RST_BURST_UP;
            rsvdHi_q        <= `RST_RSVD_HI;
        end else begin
            if (wrB1) begin
                readBurstDownEn <= cfgReq.wdata[`BIT_BURST_DN];
                readBurstUpEn   <= cfgReq.wdata[`BIT_BURST_UP];
            end
            if (wrB2) begin
                rsvdHi_q <= cfgReq.wdata[`BIT_RSVD_HI_LSB +: 5];
            end
        end
    end

    // activity flag: a new access in the clearing read cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            accessSeen_q <= 1'b0;
        end else begin
            accessSeen_q <= cardAccess || (accessSeen_q && !rdClr);
        end
    end

    // interrogation flag is wake context
    always_ff @(posedge clk) begin
        if (reset || ctxClear) begin
            queryBusy_q <= 1'b0;
        end else begin
            queryBusy_q <= queryStart || (queryBusy_q && !queryDone);
        end
    end

    // supply indicator follows the legacy power control, never a write
    always_ff @(posedge clk) begin
        if (reset) begin
            legacySupplySel_q <= `RST_SUPPLY_SEL;
        end else begin
            legacySupplySel_q <= legacySupplyIn;
        end
    end

    // configuration answer one cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            cfgRsp <= '0;
        end else begin
            cfgRsp.ack   <= rdHit || wrHit;
            cfgRsp.rdata <= rdHit ? readWord : 32'h00000000;
        end
    end

    // parity errors to syserr, clock-run hold, wake pin routing
    always_ff @(posedge clk) begin
        if (reset) begin
            serrReq         <= 1'b0;
            clkrunNOut      <= 1'b0;
            clkrunNOe       <= 1'b0;
            cardClockRunReq <= 1'b0;
            wakePinOut      <= 1'b0;
            wakePinOe       <= 1'b0;
        end else begin
            serrReq         <= parityToSyserr_q && cardParityErr;
            clkrunNOut      <= 1'b0;
            clkrunNOe       <= holdClocks_q && clkrunNs;
            cardClockRunReq <= holdClocks_q;
            if (wakeSel_q) begin
                wakePinOut <= 1'b0;
                wakePinOe  <= pmeActive;
            end else if (ringOutEn) begin
                wakePinOut <= ringIndicateOut;
                wakePinOe  <= 1'b1;
            end else begin
                wakePinOut <= 1'b0;
                wakePinOe  <= 1'b0;
            end
        end
    end

    // checks
    a_access_sets: assert property (@(posedge clk) disable iff (reset)
        cardAccess |=> accessSeen_q)
        else $error("activity flag not set after card access");

    a_read_clears: assert property (@(posedge clk) disable iff (reset)
        (rdClr && !cardAccess) |=> !accessSeen_q)
        else $error("activity flag not cleared by read");

    a_fixed_bits: assert property (@(posedge clk) disable iff (reset)
        (cfgRsp.ack && $past(rdHit)) |-> cfgRsp.rdata[12] && !cfgRsp.rdata[7]
            && !cfgRsp.rdata[3] && (cfgRsp.rdata[31:21] == 11'h000))
        else $error("fixed read bits wrong");

    a_stream_busy: assert property (@(posedge clk) disable iff (reset)
        (powerReq && !streamBusy) |=> streamBusy [*3])
        else $error("power stream busy not raised");

    a_settle_done: assert property (@(posedge clk) disable iff (reset)
        $fell(streamBusy) |-> !riseSettle && !fallSettle)
        else $error("settle flag outlives the delay");

    a_query_flag: assert property (@(posedge clk) disable iff (reset)
        (queryDone && !queryStart) |=> !queryBusy_q)
        else $error("interrogation flag not dropped");

    a_ctx_clear: assert property (@(posedge clk) disable iff (reset)
        ctxClear |=> !queryBusy_q && !riseSettle && !fallSettle)
        else $error("wake context survived bus reset");

    a_serr_gate: assert property (@(posedge clk) disable iff (reset)
        !parityToSyserr_q |=> !serrReq)
        else $error("parity error reported while disabled");

    a_wake_float: assert property (@(posedge clk) disable iff (reset)
        (!wakeSel_q && !ringOutEn) |=> !wakePinOe)
        else $error("wake pin driven while unselected");

    a_wake_pme: assert property (@(posedge clk) disable iff (reset)
        wakeSel_q |=> (wakePinOe == $past(pmeActive)) && !wakePinOut)
        else $error("wake pin not following the wake event");

    a_supply_ro: assert property (@(posedge clk) disable iff (reset)
        ##1 (legacySupplySel_q == $past(legacySupplyIn)))
        else $error("supply indicator changed by something else");
endmodule // system_control
`default_nettype wire

/* File: verif/cfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"
module cfg_host (
    input  wire logic                 clk,
    output var  sysctl_pkg::cfg_req_t cfgReq,
    input  wire sysctl_pkg::cfg_rsp_t cfgRsp
);
    int missed = 0; // register accesses that got no answer

    initial cfgReq = '0;

    // one access: request held for one edge, idle fields then inverted so nothing stale
    // looks valid, answer awaited for at most three edges
    task automatic xfer(input logic w, input logic [2:0] f, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk);
        cfgReq <= '{rd: !w, wr: w, func: f, addr: a, be: b, wdata: d};
        @(posedge clk);
        cfgReq <= '{rd: 1'b0, wr: 1'b0, func: ~f, addr: ~a, be: ~b, wdata: ~d};
        ok = 1'b0;
        q = '0;
        // the answer rises at the taking edge and stands until the next one
        for (n = 0; n < 3 && !ok; n++) begin
            #1;
            if (cfgRsp.ack === 1'b1) begin
                ok = 1'b1;
                q = cfgRsp.rdata;
            end else begin
                @(posedge clk);
            end
        end
    endtask

    // whole-register read through function 0
    task automatic rd32(output logic [31:0] q);
        logic ok;
        xfer(1'b0, `SC_FUNC, `SC_OFFSET, 4'hf, 32'h0, q, ok);
        missed += !ok;
    endtask

    // write that keeps the reserved field as it was read back
    task automatic wr32(input logic [31:0] d, input logic [3:0] b);
        logic [31:0] cur;
        logic ok;
        rd32(cur);
        xfer(1'b1, `SC_FUNC, `SC_OFFSET, b, {d[31:21], cur[20:16], d[15:0]}, cur, ok);
        missed += !ok;
    endtask
endmodule // cfg_host
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"
module tb;
    localparam logic [31:0] IMG = 32'h0004_9060; // register image after global reset
    typedef struct packed {
        logic [31:0] d;
        logic [3:0]  be;
        logic [31:0] exp;
    } row_t;
    row_t rows [5] = '{
        '{32'hffff_ffff, 4'hf, 32'h0004_d073},
        '{32'h0000_0000, 4'hf, 32'h0004_1000},
        '{32'h0000_ffff, 4'h2, 32'h0004_d000},
        '{32'h0000_ffff, 4'h1, 32'h0004_d073},
        '{32'h0000_9060, 4'hf, 32'h0004_9060}
    };
    logic clk, reset, busResetN, cardAccess, powerReq, powerUp, queryStart, queryDone;
    logic legacySupplyIn, pmeEnable, pmeActive, ringOutEn, ringIndicateOut, cardParityErr;
    logic clkrunNIn, clkrunNOut, clkrunNOe, cardClockRunReq, readBurstDownEn, readBurstUpEn;
    logic lowPowerEn, idWriteLock, serrReq, wakePinOut, wakePinOe, streamBusy, riseSettle;
    logic fallSettle, switchClk, switchData, switchLatch;
    logic [`SW_BITS-1:0]  powerCmd;
    logic [31:0]          q;
    logic                 okBit;
    sysctl_pkg::cfg_req_t cfgReq;
    sysctl_pkg::cfg_rsp_t cfgRsp;
    int errTotal = 0;
    int checkCount = 0;
    int cycles = 0;

    system_control #(.RISE_CYC(32'h14), .FALL_CYC(32'h14)) dut (
        .clk(clk), .reset(reset), .busResetN(busResetN), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
        .cardAccess(cardAccess), .powerReq(powerReq), .powerUp(powerUp), .powerCmd(powerCmd),
        .queryStart(queryStart), .queryDone(queryDone), .legacySupplyIn(legacySupplyIn),
        .pmeEnable(pmeEnable), .pmeActive(pmeActive), .ringOutEn(ringOutEn),
        .ringIndicateOut(ringIndicateOut), .cardParityErr(cardParityErr),
        .clkrunNIn(clkrunNIn), .clkrunNOut(clkrunNOut), .clkrunNOe(clkrunNOe),
        .cardClockRunReq(cardClockRunReq), .readBurstDownEn(readBurstDownEn),
        .readBurstUpEn(readBurstUpEn), .lowPowerEn(lowPowerEn), .idWriteLock(idWriteLock),
        .serrReq(serrReq), .wakePinOut(wakePinOut), .wakePinOe(wakePinOe),
        .streamBusy(streamBusy), .riseSettle(riseSettle), .fallSettle(fallSettle),
        .switchClk(switchClk), .switchData(switchData), .switchLatch(switchLatch));

    cfg_host host (.clk(clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

    // compare helpers, one per result width
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [31:0] e);
        host.rd32(q);
        chk32(q, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic gReset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
    endtask
    task automatic busRst;
        @(posedge clk);
        busResetN <= 1'b0;
        repeat (6) @(posedge clk);
        busResetN <= 1'b1;
        cyc(8);
    endtask
    // one power change: count switch bits, check flags while settling and at the end
    task automatic powerRun(input logic up, input logic [31:0] flag);
        int n;
        int clks;
        clks = 0;
        @(posedge clk);
        powerUp <= up;
        powerReq <= 1'b1;
        @(posedge clk);
        powerReq <= 1'b0;
        for (n = 0; n < 300 && switchLatch !== 1'b1; n++) begin
            cyc(1);
            if (switchClk === 1'b1) begin
                chk1(switchData, powerCmd[7 - clks]);
                clks++;
            end
        end
        chk1(switchLatch, 1'b1);
        chk32(clks, 32'h8);
        cyc(2);
        chk1(streamBusy, 1'b1);
        chk1(up ? riseSettle : fallSettle, 1'b1);
        rdChk(IMG | 32'h800 | flag);
        for (n = 0; n < 60 && streamBusy === 1'b1; n++) cyc(1);
        chk1(streamBusy | riseSettle | fallSettle, 1'b0);
    endtask
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errTotal++;
            testDone();
        end
    end

    // main sequence
    initial begin
        {cardAccess, powerReq, powerUp, queryStart, queryDone, legacySupplyIn} = '0;
        {pmeEnable, pmeActive, ringOutEn, ringIndicateOut, cardParityErr, clkrunNIn} = '0;
        powerCmd = 8'ha5;
        busResetN = 1'b1;
        reset = 1'b1;
        gReset();
        rdChk(IMG);
        foreach (rows[i]) begin
            host.wr32(rows[i].d, rows[i].be);
            rdChk(rows[i].exp);
            chk1(readBurstDownEn, rows[i].exp[15]);
            chk1(readBurstUpEn, rows[i].exp[14]);
            chk1(lowPowerEn, rows[i].exp[6]);
            chk1(idWriteLock, rows[i].exp[5]);
            chk1(cardClockRunReq, rows[i].exp[1]);
        end
        @(posedge clk);
        cardAccess <= 1'b1;
        @(posedge clk);
        cardAccess <= 1'b0;
        rdChk(IMG | 32'h2000);
        rdChk(IMG);
        @(posedge clk);
        legacySupplyIn <= 1'b1;
        rdChk(IMG | 32'h4);
        legacySupplyIn <= 1'b0;
        host.xfer(1'b0, 3'h0, 8'h84, 4'hf, 32'h0, q, okBit);
        chk1(okBit, 1'b0);
        host.xfer(1'b0, 3'h1, 8'h80, 4'hf, 32'h0, q, okBit);
        chk1(okBit, 1'b0);
        powerRun(1'b1, 32'h400);
        powerRun(1'b0, 32'h200);
        rdChk(IMG);
        @(posedge clk);
        queryStart <= 1'b1;
        pmeEnable <= 1'b1;
        @(posedge clk);
        queryStart <= 1'b0;
        rdChk(IMG | 32'h100);
        busRst();
        rdChk(IMG | 32'h100);
        pmeEnable <= 1'b0;
        busRst();
        rdChk(IMG);
        @(posedge clk);
        queryStart <= 1'b1;
        @(posedge clk);
        queryStart <= 1'b0;
        queryDone <= 1'b1;
        @(posedge clk);
        queryDone <= 1'b0;
        rdChk(IMG);
        for (int k = 0; k < 8; k++) begin
            host.wr32(IMG | k[1], 4'h1);
            @(posedge clk);
            ringOutEn <= k[0];
            pmeActive <= k[2];
            ringIndicateOut <= k[2];
            cyc(3);
            chk1(wakePinOe, k[1] ? k[2] : k[0]);
            if (wakePinOe === 1'b1) chk1(wakePinOut, k[1] ? 1'b0 : k[2]);
        end
        ringOutEn <= 1'b0;
        host.wr32(IMG | 32'h10, 4'h1);
        cardParityErr <= 1'b1;
        cyc(3);
        chk1(serrReq, 1'b1);
        host.wr32(IMG, 4'h1);
        cyc(2);
        chk1(serrReq, 1'b0);
        clkrunNIn <= 1'b1;
        cyc(6);
        chk1(clkrunNOe, 1'b0);
        host.wr32(IMG | 32'h2, 4'h1);
        cyc(6);
        chk1(clkrunNOe, 1'b1);
        chk1(clkrunNOut, 1'b0);
        clkrunNIn <= 1'b0;
        cyc(6);
        chk1(clkrunNOe, 1'b0);
        host.wr32(32'h0000_ffff, 4'h3);
        gReset();
        rdChk(IMG);
        chk1(readBurstUpEn | wakePinOe, 1'b0);
        chk32(host.missed, 32'h0);
        testDone();
    end
endmodule // tb
`default_nettype wire
